/* File: verilog/cce_pkg.sv */
// Purpose: constants, types and helpers of the call/clear/compare executor
// Assumes: one accepted instruction word per instruction cycle
// Notes:   register offsets are byte addresses on the Avalon-MM slave
package cce_pkg;
   // ==========================================================
   // widths
   localparam int DMEM_AW = 12;
   localparam int PC_W    = 21;
   // ==========================================================
   // register map (byte offsets)
   localparam logic [15:0] OFS_CTRL     = 16'h0000;
   localparam logic [15:0] OFS_ACC      = 16'h0004;
   localparam logic [15:0] OFS_FLAGS    = 16'h0008;
   localparam logic [15:0] OFS_BANK     = 16'h000c;
   localparam logic [15:0] OFS_IDXBASE  = 16'h0010;
   localparam logic [15:0] OFS_ACC_SH   = 16'h0014;
   localparam logic [15:0] OFS_FLAGS_SH = 16'h0018;
   localparam logic [15:0] OFS_BANK_SH  = 16'h001c;
   localparam logic [15:0] OFS_PC       = 16'h0020;
   localparam logic [15:0] OFS_STKTOP   = 16'h0024;
   localparam logic [15:0] OFS_WDT      = 16'h0028;
   localparam logic [15:0] OFS_CYCLES   = 16'h002c;
   localparam logic [1:0]  MEM_WIN      = 2'b01;
   // ==========================================================
   // field positions and reset values
   localparam int CTRL_EXT_BIT  = 0;
   localparam int FLAG_Z_BIT    = 2;
   localparam int FLAG_N_BIT    = 4;
   localparam int WDT_TMO_BIT   = 0;
   localparam int WDT_SLEEP_BIT = 1;
   localparam logic [7:0]      FLAGS_RST = 8'h00;
   localparam logic [1:0]      WDT_RST   = 2'h3;
   localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
   localparam logic [PC_W-1:0] RET_OFS   = 21'h000004;
   // ==========================================================
   // encodings
   localparam logic [6:0]  OP_CALL   = 7'h76;
   localparam logic [3:0]  OP_CALL2  = 4'hf;
   localparam logic [6:0]  OP_CLR    = 7'h35;
   localparam logic [5:0]  OP_INV    = 6'h07;
   localparam logic [6:0]  OP_SKEQ   = 7'h31;
   localparam logic [15:0] OP_KICK   = 16'h0004;
   localparam logic [7:0]  ACC_LIMIT = 8'h5f;
   localparam logic [3:0]  SFR_BANK  = 4'hf;
   // ==========================================================
   // types
   typedef enum logic [3:0] {
      ST_DECODE = 4'h1,
      ST_CALL2  = 4'h2,
      ST_SKIP1  = 4'h4,
      ST_SKIP2  = 4'h8
   } cce_state_t;
   typedef struct packed {
      logic       dest;
      logic       acc;
      logic [7:0] f;
   } cce_fop_t;
   // two-word opcodes whose second word must also be discarded on a skip
   function automatic logic cce_two_word(input logic [15:0] w);
      cce_two_word = (w[15:12] == 4'hc) || (w[15:9] == OP_CALL) ||
                     (w[15:8] == 8'hef) || (w[15:8] == 8'hee) || (w[15:8] == 8'heb);
   endfunction
   function automatic logic [31:0] cce_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      cce_merge = (o & ~m) | (n & m);
   endfunction
endpackage

/* File: verilog/cce_exec.sv */
// Purpose: executes call, clear-file, watchdog kick, invert-file and skip-if-equal
// Assumes: instr_valid marks one instruction word, one instruction cycle per word
// Notes:   data memory is held here and also visible through the bus window
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module cce_exec import cce_pkg::*; (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // instruction words
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   // watchdog side
   output logic             wdt_kick,
   // avalon-mm slave
   input  wire logic [15:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);
   // ==========================================================
   // state
   cce_state_t        state_r, state_nxt;
   logic              ext_en_r, ext_en_nxt;
   logic [7:0]        acc_r, acc_nxt;
   logic [7:0]        flags_r, flags_nxt;
   logic [3:0]        bank_r, bank_nxt;
   logic [11:0]       idxbase_r, idxbase_nxt;
   logic [7:0]        acc_sh_r, acc_sh_nxt;
   logic [7:0]        flags_sh_r, flags_sh_nxt;
   logic [3:0]        bank_sh_r, bank_sh_nxt;
   logic [PC_W-1:0]   pc_r, pc_nxt;
   logic [PC_W-1:0]   stktop_r, stktop_nxt;
   logic [7:0]        klo_r, klo_nxt;
   logic [1:0]        wdt_r, wdt_nxt;
   logic [31:0]       cycles_r, cycles_nxt;
   logic              kick_r, kick_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              wait_r, wait_nxt;
   logic [7:0]        dmem [2**DMEM_AW];
   // ==========================================================
   // combinational helpers
   cce_fop_t          fop;
   logic [DMEM_AW-1:0] daddr;
   logic [7:0]        fval;
   logic [7:0]        inv;
   logic              core_we;
   logic [7:0]        core_wd;
   logic              bus_wr;
   logic              mem_sel;
   logic [DMEM_AW-1:0] mem_idx;
   logic [31:0]       rsel;
   logic [31:0]       wm;
   logic              is_call;
   logic              is_clear;
   logic              is_kick;
   logic              is_invert;
   logic              is_skip;

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;
   assign wdt_kick        = kick_r;
   assign mem_sel         = avs_address[15:14] == MEM_WIN;
   assign mem_idx         = avs_address[DMEM_AW+1:2];
   assign bus_wr          = avs_write && !wait_r;
   // opcode classes of the word on the instruction port
   assign is_call         = instr_word[15:9] == OP_CALL;
   assign is_clear        = instr_word[15:9] == OP_CLR;
   assign is_kick         = instr_word == OP_KICK;
   assign is_invert       = instr_word[15:10] == OP_INV;
   assign is_skip         = instr_word[15:9] == OP_SKEQ;

   // ==========================================================
   // file address resolution
   always_comb begin
      fop = cce_fop_t'(instr_word[9:0]);
      // flag set: banked; clear: access bank, offsets up to 0x5f indexed in the extended set
      if (fop.acc) begin
         daddr = {bank_r, fop.f};
      end else if (ext_en_r && fop.f <= ACC_LIMIT) begin
         daddr = idxbase_r + {4'h0, fop.f};
      end else if (fop.f <= ACC_LIMIT) begin
         daddr = {4'h0, fop.f};
      end else begin
         daddr = {SFR_BANK, fop.f};
      end
      fval = dmem[daddr];
      inv  = ~fval;
   end

   // ==========================================================
   // instruction execution and bus registers
   always_comb begin
      state_nxt    = state_r;
      ext_en_nxt   = ext_en_r;
      acc_nxt      = acc_r;
      flags_nxt    = flags_r;
      bank_nxt     = bank_r;
      idxbase_nxt  = idxbase_r;
      acc_sh_nxt   = acc_sh_r;
      flags_sh_nxt = flags_sh_r;
      bank_sh_nxt  = bank_sh_r;
      pc_nxt       = pc_r;
      stktop_nxt   = stktop_r;
      klo_nxt      = klo_r;
      wdt_nxt      = wdt_r;
      cycles_nxt   = cycles_r;
      kick_nxt     = 1'b0;
      core_we      = 1'b0;
      core_wd      = 8'h00;
      wm           = 32'h0;
      if (instr_valid) begin
         // every accepted word is counted; all but a prefixed call second word step pc, discarded ones too
         cycles_nxt = cycles_r + 32'h1;
         pc_nxt     = pc_r + PC_STEP;
         unique case (state_r)
            ST_DECODE: begin
               if (is_call) begin
                  stktop_nxt = pc_r + RET_OFS;
                  klo_nxt    = instr_word[7:0];
                  state_nxt  = ST_CALL2;
                  if (instr_word[8]) begin
                     acc_sh_nxt   = acc_r;
                     flags_sh_nxt = flags_r;
                     bank_sh_nxt  = bank_r;
                  end
               end else if (is_clear) begin
                  core_we               = 1'b1;
                  core_wd               = 8'h00;
                  flags_nxt[FLAG_Z_BIT] = 1'b1;
               end else if (is_kick) begin
                  kick_nxt = 1'b1;
                  wdt_nxt  = WDT_RST;
               end else if (is_invert) begin
                  flags_nxt[FLAG_N_BIT] = inv[7];
                  flags_nxt[FLAG_Z_BIT] = inv == 8'h00;
                  if (fop.dest) begin
                     core_we = 1'b1;
                     core_wd = inv;
                  end else begin
                     acc_nxt = inv;
                  end
               end else if (is_skip) begin
                  if (fval - acc_r == 8'h00) begin
                     state_nxt = ST_SKIP1;
                  end
               end
            end
            ST_CALL2: begin
               state_nxt = ST_DECODE;
               // a second word without the prefix is a plain word: no jump
               if (instr_word[15:12] == OP_CALL2) begin
                  pc_nxt = {instr_word[11:0], klo_r, 1'b0};
               end
            end
            ST_SKIP1: begin
               state_nxt = cce_two_word(instr_word) ? ST_SKIP2 : ST_DECODE;
            end
            ST_SKIP2: begin
               state_nxt = ST_DECODE;
            end
         endcase
      end
      // bus writes land after the core update and override it
      if (bus_wr && !mem_sel) begin
         wm = cce_merge(32'h0, avs_writedata, avs_byteenable);
         // narrow registers take lane 0, the index base lanes 0 and 1
         unique case (avs_address)
            OFS_CTRL: begin
               if (avs_byteenable[0]) begin
                  ext_en_nxt = wm[CTRL_EXT_BIT];
               end
            end
            OFS_ACC: begin
               if (avs_byteenable[0]) begin
                  acc_nxt = wm[7:0];
               end
            end
            OFS_FLAGS: begin
               if (avs_byteenable[0]) begin
                  flags_nxt = wm[7:0];
               end
            end
            OFS_BANK: begin
               if (avs_byteenable[0]) begin
                  bank_nxt = wm[3:0];
               end
            end
            OFS_IDXBASE: begin
               if (avs_byteenable[0]) begin
                  idxbase_nxt[7:0] = wm[7:0];
               end
               if (avs_byteenable[1]) begin
                  idxbase_nxt[11:8] = wm[11:8];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // bus read mux and handshake
   always_comb begin
      rsel = 32'h0;
      // memory window shows one byte per word, upper bits read zero
      if (mem_sel) begin
         rsel = {24'h0, dmem[mem_idx]};
      end else begin
         unique case (avs_address)
            OFS_CTRL:     rsel = {31'h0, ext_en_r};
            OFS_ACC:      rsel = {24'h0, acc_r};
            OFS_FLAGS:    rsel = {24'h0, flags_r};
            OFS_BANK:     rsel = {28'h0, bank_r};
            OFS_IDXBASE:  rsel = {20'h0, idxbase_r};
            OFS_ACC_SH:   rsel = {24'h0, acc_sh_r};
            OFS_FLAGS_SH: rsel = {24'h0, flags_sh_r};
            OFS_BANK_SH:  rsel = {28'h0, bank_sh_r};
            OFS_PC:       rsel = {11'h0, pc_r};
            OFS_STKTOP:   rsel = {11'h0, stktop_r};
            OFS_WDT:      rsel = {30'h0, wdt_r};
            OFS_CYCLES:   rsel = cycles_r;
            default:      rsel = 32'h0;
         endcase
      end
      // waitrequest drops for one cycle, one cycle after a request rises
      wait_nxt  = !((avs_read || avs_write) && wait_r);
      rdata_nxt = (avs_read && wait_r) ? rsel : rdata_r;
   end

   // ==========================================================
   // registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r    <= ST_DECODE;
         ext_en_r   <= 1'b0;
         acc_r      <= 8'h00;
         flags_r    <= FLAGS_RST;
         bank_r     <= 4'h0;
         idxbase_r  <= 12'h000;
         acc_sh_r   <= 8'h00;
         flags_sh_r <= FLAGS_RST;
         bank_sh_r  <= 4'h0;
         pc_r       <= 21'h000000;
         stktop_r   <= 21'h000000;
         klo_r      <= 8'h00;
         wdt_r      <= WDT_RST;
         cycles_r   <= 32'h0;
         kick_r     <= 1'b0;
         rdata_r    <= 32'h0;
         wait_r     <= 1'b1;
      end else begin
         state_r    <= state_nxt;
         ext_en_r   <= ext_en_nxt;
         acc_r      <= acc_nxt;
         flags_r    <= flags_nxt;
         bank_r     <= bank_nxt;
         idxbase_r  <= idxbase_nxt;
         acc_sh_r   <= acc_sh_nxt;
         flags_sh_r <= flags_sh_nxt;
         bank_sh_r  <= bank_sh_nxt;
         pc_r       <= pc_nxt;
         stktop_r   <= stktop_nxt;
         klo_r      <= klo_nxt;
         wdt_r      <= wdt_nxt;
         cycles_r   <= cycles_nxt;
         kick_r     <= kick_nxt;
         rdata_r    <= rdata_nxt;
         wait_r     <= wait_nxt;
      end
   end

   // data memory: a bus write wins over a core write in the same cycle
   // its contents survive reset, so it is loaded over the bus
   always_ff @(posedge clock) begin
      if (bus_wr && mem_sel && avs_byteenable[0]) begin
         dmem[mem_idx] <= avs_writedata[7:0];
      end else if (core_we && !sys_rst) begin
         dmem[daddr] <= core_wd;
      end
   end
endmodule

/* File: tb/cce_exec_monitor.sv */
// Purpose: port-level checks of the instruction executor
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only the top ports, attached by bind
`timescale 1ns/10ps
module cce_exec_monitor import cce_pkg::*; (
   // clock and reset
   input wire logic        clock,
   input wire logic        sys_rst,
   // instruction words
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic        wdt_kick,
   // avalon-mm
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   // ==========================================================
   // sequences
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence kick_taken;
      instr_valid && instr_word == OP_KICK;
   endsequence
   sequence req_start;
      $rose(avs_read || avs_write) && avs_waitrequest;
   endsequence
   // ==========================================================
   // assertions
   kick_follow_a: assert property (kick_taken |=> wdt_kick)
      else $error("kick word gave no kick pulse");
   kick_cause_a: assert property (wdt_kick |->
      $past(instr_valid) && $past(instr_word) == OP_KICK)
      else $error("kick pulse without kick word");
   kick_pulse_a: assert property (wdt_kick && !(instr_valid && instr_word == OP_KICK)
      |=> !wdt_kick)
      else $error("kick pulse longer than one cycle");
   wait_answer_a: assert property (req_start |=> !avs_waitrequest)
      else $error("request not answered after one cycle");
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for two cycles");
   wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
      else $error("waitrequest low without request");
   rdata_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata))
      else $error("readdata changed without read");
   reset_quiet_a: assert property ($fell(sys_rst) |-> avs_waitrequest && !wdt_kick)
      else $error("outputs active at reset release");
endmodule

/* File: tb/cce_exec_tb.sv */
// Purpose: directed bench of the instruction executor
// Assumes: bus answers with waitrequest; one word per cycle on the instruction port
// Notes:   data memory loaded and checked through the bus window
`timescale 1ns/10ps
module cce_exec_tb import cce_pkg::*; ;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   logic        instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0;
   logic [15:0] avs_address = 16'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        wdt_kick;
   logic [31:0] p;
   logic [31:0] s;
   int          error_cnt = 0;
   int          checked = 0;
   always #10 clock = ~clock;
   cce_exec cce_exec_inst (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr_word(instr_word), .wdt_kick(wdt_kick), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   // ==========================================================
   // tasks
   task automatic wrap_up;
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int i;
      @(posedge clock);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20) begin
         error_cnt++;
         wrap_up;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic rc(input string n, input logic [15:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask
   task automatic run(input logic [15:0] w0, w1, w2, input int n);
      logic [15:0] w [3];
      w = '{w0, w1, w2};
      for (int k = 0; k < n; k++) begin
         @(posedge clock);
         instr_valid <= 1'b1;
         instr_word  <= w[k];
      end
      @(posedge clock);
      instr_valid <= 1'b0;
   endtask
   function automatic logic [15:0] ma(input logic [11:0] k);
      ma = {MEM_WIN, k, 2'b00};
   endfunction
   // ==========================================================
   // scenarios
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      rc("flags", OFS_FLAGS, {24'h0, FLAGS_RST});
      rc("wdt", OFS_WDT, {30'h0, WDT_RST});
      wr(16'h0030, 32'h55);
      rc("unmapped", 16'h0030, 32'h0);
      wr(OFS_PC, 32'h1234);
      rc("pc ro", OFS_PC, 32'h0);
      // clear through bank select, access bank and the upper area
      wr(OFS_BANK, 32'h2);
      wr(ma(12'h205), 32'h5a);
      wr(ma(12'h010), 32'h33);
      wr(ma(12'hf80), 32'h44);
      run({OP_CLR, 1'b1, 8'h05}, {OP_CLR, 1'b0, 8'h10}, {OP_CLR, 1'b0, 8'h80}, 3);
      rc("clr bank", ma(12'h205), 32'h0);
      rc("clr access", ma(12'h010), 32'h0);
      rc("clr upper", ma(12'hf80), 32'h0);
      rc("clr z", OFS_FLAGS, 32'h1 << FLAG_Z_BIT);
      rc("clr cycles", OFS_CYCLES, 32'h3);
      // indexed mode with the extended set on
      wr(OFS_CTRL, 32'h1);
      wr(OFS_IDXBASE, 32'h300);
      wr(ma(12'h305), 32'h66);
      wr(ma(12'hf60), 32'h77);
      wr(ma(12'h005), 32'h88);
      run({OP_CLR, 1'b0, 8'h05}, {OP_CLR, 1'b0, 8'h60}, 16'h0, 2);
      rc("idx", ma(12'h305), 32'h0);
      rc("idx above", ma(12'hf60), 32'h0);
      rc("idx direct", ma(12'h005), 32'h88);
      wr(OFS_CTRL, 32'h0);
      // invert to accumulator, then back to the register
      wr(ma(12'h210), 32'h13);
      wr(ma(12'h211), 32'hff);
      run({OP_INV, 1'b0, 1'b1, 8'h10}, 16'h0, 16'h0, 1);
      rc("inv acc", OFS_ACC, 32'hec);
      rc("inv src", ma(12'h210), 32'h13);
      rc("inv n", OFS_FLAGS, 32'h1 << FLAG_N_BIT);
      run({OP_INV, 1'b1, 1'b1, 8'h11}, 16'h0, 16'h0, 1);
      rc("inv reg", ma(12'h211), 32'h0);
      rc("inv z", OFS_FLAGS, 32'h1 << FLAG_Z_BIT);
      // skip over one-word and two-word instructions
      wr(OFS_ACC, 32'h42);
      wr(ma(12'h220), 32'h42);
      wr(ma(12'h221), 32'h77);
      wr(OFS_FLAGS, 32'h10);
      rd(OFS_PC, p);
      rd(OFS_STKTOP, s);
      run({OP_SKEQ, 1'b1, 8'h20}, {OP_CLR, 1'b1, 8'h21}, 16'h0, 2);
      rc("skip word", ma(12'h221), 32'h77);
      rc("skip flags", OFS_FLAGS, 32'h10);
      rc("skip pc", OFS_PC, p + 32'h4);
      run({OP_SKEQ, 1'b1, 8'h20}, {OP_CALL, 1'b1, 8'h21}, {OP_CALL2, 12'h000}, 3);
      rc("skip2 stack", OFS_STKTOP, s);
      rc("skip2 pc", OFS_PC, p + 32'ha);
      run({OP_CLR, 1'b1, 8'h21}, 16'h0, 16'h0, 1);
      rc("after skip", ma(12'h221), 32'h0);
      wr(OFS_ACC, 32'h41);
      wr(ma(12'h221), 32'h77);
      run({OP_SKEQ, 1'b1, 8'h20}, {OP_CLR, 1'b1, 8'h21}, 16'h0, 2);
      rc("no skip", ma(12'h221), 32'h0);
      // skip over a two-word jump: its second word must not execute
      wr(ma(12'h221), 32'h77);
      wr(OFS_ACC, 32'h42);
      run({OP_SKEQ, 1'b1, 8'h20}, 16'hef00, {OP_CLR, 1'b1, 8'h21}, 3);
      rc("skip2 word", ma(12'h221), 32'h77);
      // call with and without fast save
      wr(OFS_ACC, 32'h5a);
      wr(OFS_FLAGS, 32'h14);
      rd(OFS_PC, p);
      rd(OFS_CYCLES, s);
      run({OP_CALL, 1'b1, 8'hcd}, {OP_CALL2, 12'hab1}, 16'h0, 2);
      rc("call pc", OFS_PC, 32'h15639a);
      rc("call stack", OFS_STKTOP, p + 32'h4);
      rc("call cycles", OFS_CYCLES, s + 32'h2);
      rc("acc shadow", OFS_ACC_SH, 32'h5a);
      rc("flags shadow", OFS_FLAGS_SH, 32'h14);
      rc("bank shadow", OFS_BANK_SH, 32'h2);
      wr(OFS_ACC, 32'h11);
      run({OP_CALL, 1'b0, 8'h02}, {OP_CALL2, 12'h000}, 16'h0, 2);
      rc("shadow kept", OFS_ACC_SH, 32'h5a);
      rc("call2 pc", OFS_PC, 32'h4);
      run({OP_CALL, 1'b0, 8'h02}, 16'h0, 16'h0, 2);
      rc("call no prefix", OFS_PC, 32'h8);
      // watchdog kick
      run(OP_KICK, 16'h0, 16'h0, 1);
      #1 chk("wdt_kick", 32'h1, {31'h0, wdt_kick});
      rc("wdt kick", OFS_WDT, 32'h3);
      wrap_up;
   end
endmodule
bind cce_exec cce_exec_monitor cce_exec_monitor_inst (.clock(clock), .sys_rst(sys_rst),
   .instr_valid(instr_valid), .instr_word(instr_word), .wdt_kick(wdt_kick),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest));
